//--- uopc_cfg.svh
`ifndef UOPC_CFG_SVH
`define UOPC_CFG_SVH
// Register byte addresses on the APB bus
`define UOPC_ADDR_LINE 12'h000
`define UOPC_ADDR_PWR 12'h004
`define UOPC_ADDR_EVT 12'h008
`define UOPC_ADDR_ERREN 12'h00C
`define UOPC_ADDR_MAIN 12'h010
`define UOPC_ADDR_TSTAT 12'h014
// Line/power control field positions
`define UOPC_DP_PU 7
`define UOPC_DM_PU 6
`define UOPC_DP_PD 5
`define UOPC_DM_PD 4
`define UOPC_BUS_PWR 3
`define UOPC_DUAL_EN 2
`define UOPC_CHG_SEL 1
`define UOPC_DIS_EN 0
// Power register field positions
`define UOPC_ACT_PND 7
`define UOPC_SLP_GRD 4
`define UOPC_SUSP 1
`define UOPC_OP_EN 0
// Event register field positions
`define UOPC_EV_STALL 7
`define UOPC_EV_RESUME 5
`define UOPC_EV_QUIET 4
`define UOPC_EV_TOKEN 3
`define UOPC_EV_FRAME 2
`define UOPC_EV_ERR 1
`define UOPC_EV_RESET 0
// Main control field positions
`define UOPC_HOST_EN 3
`define UOPC_PERI_EN 0
// Readable masks of the implemented bits
`define UOPC_LINE_MASK 8'hFF
`define UOPC_PWR_MASK 8'h93
`define UOPC_EVT_MASK 8'hBF
// Timing: resume/reset 2500 ns, idle 3 ms, at 100 ns clock
`define UOPC_CLK_NS 100
`define UOPC_KSTATE_NS 2500
`define UOPC_IDLE_NS 3000000
`define UOPC_KSTATE_CYC ((`UOPC_KSTATE_NS + `UOPC_CLK_NS - 1) / `UOPC_CLK_NS)
`define UOPC_IDLE_CYC ((`UOPC_IDLE_NS + `UOPC_CLK_NS - 1) / `UOPC_CLK_NS)
`endif

//--- uopc_pkg.sv
package uopc_pkg;
    // Line state seen on D+/D- after synchronising
    typedef enum logic [1:0] {
        UOPC_LS_SE0 = 2'b00,
        UOPC_LS_J = 2'b01,
        UOPC_LS_K = 2'b10,
        UOPC_LS_SE1 = 2'b11
    } uopc_line_t;
    // Tracker of the bus reset condition
    typedef enum logic [1:0] {
        UOPC_RS_IDLE = 2'b00,
        UOPC_RS_TIMING = 2'b01,
        UOPC_RS_HELD = 2'b10
    } uopc_rst_state_t;
endpackage : uopc_pkg

//--- uopc_persist.sv
`timescale 1ns/100ps
// Counts consecutive cycles of a condition, pulses once at the threshold
module uopc_persist #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] LIMIT = 16'h0019
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Condition and result
    input wire logic i_cond,
    output logic o_hit
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic hit;
    } uopc_persist_st_t;
    uopc_persist_st_t st_q, st_d;

    // Count while the condition holds, restart when it drops
    always_comb begin
        st_d = st_q;
        st_d.hit = 1'b0;
        if (!i_cond) begin
            st_d.cnt = '0;
        end else if (st_q.cnt < LIMIT) begin
            st_d.cnt = st_q.cnt + 1'b1;
            st_d.hit = (st_q.cnt == LIMIT - 1'b1);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_hit = st_q.hit;
endmodule : uopc_persist

//--- uopc_top.sv
`timescale 1ns/100ps
`include "uopc_cfg.svh"
//
// Functional notes
// - Four enable bits 7..4 connect D+/D- pull-ups and pull-downs when set, while dual-role bit 2 is set.
// - Upper byte of each control/status register reads as zero.
// - Activity pending set while bus activity forbids suspend, with guard.
// - Suspend bit gates USB clock, lowers transceiver; hardware may clear.
// - Operation enable bit enables the whole module; zero disables it, but suspend bit still drives clock gate and transceiver.
// - Stall flag set when a STALL handshake was sent as peripheral.
// - Resume flag set when K-state persists 2.5 us on the data lines.
// - Quiet flag set when the bus stays idle 3 ms or more.
// - Token flag set when current token processing completes.
// - Clearing the token flag advances the token status FIFO.
// - Frame flag set on received SOF or host SOF threshold.
// - Read-only error summary high only for enabled error conditions.
// - Bus reset flag set once valid reset lasted 2.5 us.
// - Bus reset flag not set again until bus leaves reset.
// - Writing one clears a flag, except the error summary and a token flag with FIFO entries left; whole word written at once.
// - Stall, resume, quiet and reset flags set only in peripheral operation.
module uopc_top #(
    parameter int IDLE_CYC = `UOPC_IDLE_CYC,
    parameter int KSTATE_CYC = `UOPC_KSTATE_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // USB data lines (pins)
    input wire logic i_dplus,
    input wire logic i_dminus,
    // Events from the USB protocol engine (same clock)
    input wire logic i_low_speed,
    input wire logic i_stall_sent,
    input wire logic i_token_done,
    input wire logic [7:0] i_token_info,
    input wire logic i_sof_seen,
    input wire logic i_sof_threshold,
    input wire logic [7:0] i_error_flags,
    input wire logic i_bus_active,
    // Line resistor and bus power controls
    output logic o_dplus_pullup_en,
    output logic o_dminus_pullup_en,
    output logic o_dplus_pulldown_en,
    output logic o_dminus_pulldown_en,
    output logic o_bus_power_on,
    output logic o_bus_charge_select,
    output logic o_bus_discharge_en,
    // Module power state
    output logic o_module_en,
    output logic o_usb_clk_gate,
    output logic o_xcvr_low_power
);
    localparam int FIFO_DEPTH = 4;

    typedef struct packed {
        logic [1:0] dp_sync;
        logic [1:0] dm_sync;
        logic [7:0] line_ctl;
        logic sleep_guard;
        logic suspend_request;
        logic module_operation_en;
        logic activity_pending;
        logic [7:0] flags;
        logic [7:0] err_en;
        logic host_role_en;
        logic peripheral_role_en;
        uopc_pkg::uopc_rst_state_t rst_st;
        logic [FIFO_DEPTH-1:0][7:0] fifo;
        logic [2:0] fifo_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [6:0] pins;
        logic [2:0] pwr;
    } uopc_st_t;
    uopc_st_t st_q, st_d;

    // -------------------------------------------------------------
    // Line state decode and persistence timers
    // -------------------------------------------------------------
    uopc_pkg::uopc_line_t line;
    logic k_state;
    logic idle_state;
    logic se0_state;
    logic resume_hit;
    logic quiet_hit;
    logic reset_hit;

    // K is diff one at low speed, diff zero at full speed
    always_comb begin
        line = uopc_pkg::uopc_line_t'({st_q.dm_sync[1], st_q.dp_sync[1]});
        k_state = i_low_speed ? (line == uopc_pkg::UOPC_LS_J) :
            (line == uopc_pkg::UOPC_LS_K);
        idle_state = i_low_speed ? (line == uopc_pkg::UOPC_LS_K) :
            (line == uopc_pkg::UOPC_LS_J);
        se0_state = (line == uopc_pkg::UOPC_LS_SE0);
    end

    uopc_persist #(
        .WIDTH(8),
        .LIMIT(8'(KSTATE_CYC))
    ) u_resume (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_cond(k_state && st_q.module_operation_en),
        .o_hit(resume_hit)
    );

    uopc_persist #(
        .WIDTH(16),
        .LIMIT(16'(IDLE_CYC))
    ) u_quiet (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_cond(idle_state && st_q.module_operation_en),
        .o_hit(quiet_hit)
    );

    uopc_persist #(
        .WIDTH(8),
        .LIMIT(8'(KSTATE_CYC))
    ) u_reset (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_cond(se0_state && st_q.module_operation_en),
        .o_hit(reset_hit)
    );

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    logic acc;
    logic wr;
    logic rd;
    logic [7:0] set_ev;
    logic [7:0] clr_ev;
    logic [7:0] rdata;
    logic hit;
    logic pop;
    logic push;
    logic dual;

    always_comb begin
        st_d = st_q;
        acc = i_psel && i_penable && !st_q.pready;
        // Writes commit at the edge that sees the ready pulse
        wr = i_psel && i_penable && st_q.pready && i_pwrite;
        rd = acc && !i_pwrite;
        set_ev = 8'h00;
        clr_ev = 8'h00;
        rdata = 8'h00;
        hit = 1'b1;
        pop = 1'b0;
        push = 1'b0;
        dual = st_q.line_ctl[`UOPC_DUAL_EN];
        // Pins pass two flops before anything reads them
        st_d.dp_sync = {st_q.dp_sync[0], i_dplus};
        st_d.dm_sync = {st_q.dm_sync[0], i_dminus};

        // Bus reset tracker: one flag per reset episode
        case (st_q.rst_st)
            uopc_pkg::UOPC_RS_IDLE: begin
                if (se0_state) begin
                    st_d.rst_st = uopc_pkg::UOPC_RS_TIMING;
                end
            end
            uopc_pkg::UOPC_RS_TIMING: begin
                if (reset_hit) begin
                    set_ev[`UOPC_EV_RESET] = 1'b1;
                    st_d.rst_st = uopc_pkg::UOPC_RS_HELD;
                end else if (!se0_state) begin
                    st_d.rst_st = uopc_pkg::UOPC_RS_IDLE;
                end
            end
            uopc_pkg::UOPC_RS_HELD: begin
                if (!se0_state) begin
                    st_d.rst_st = uopc_pkg::UOPC_RS_IDLE;
                end
            end
            default: st_d.rst_st = uopc_pkg::UOPC_RS_IDLE;
        endcase

        // Peripheral events; flags only in peripheral role
        if (st_q.peripheral_role_en && !st_q.host_role_en) begin
            set_ev[`UOPC_EV_STALL] = i_stall_sent;
            set_ev[`UOPC_EV_RESUME] = resume_hit;
            set_ev[`UOPC_EV_QUIET] = quiet_hit;
            set_ev[`UOPC_EV_FRAME] = i_sof_seen;
        end else begin
            set_ev[`UOPC_EV_RESET] = 1'b0;
        end
        if (st_q.host_role_en) begin
            set_ev[`UOPC_EV_FRAME] = i_sof_threshold;
        end
        if (!st_q.module_operation_en) begin
            set_ev = 8'h00;
        end

        // Register decode
        case (i_paddr)
            `UOPC_ADDR_LINE: rdata = st_q.line_ctl;
            `UOPC_ADDR_PWR: rdata = {st_q.activity_pending, 2'b00,
                st_q.sleep_guard, 2'b00, st_q.suspend_request,
                st_q.module_operation_en};
            `UOPC_ADDR_EVT: rdata = st_q.flags & `UOPC_EVT_MASK;
            `UOPC_ADDR_ERREN: rdata = st_q.err_en;
            `UOPC_ADDR_MAIN: rdata = {4'h0, st_q.host_role_en, 2'b00,
                st_q.peripheral_role_en};
            `UOPC_ADDR_TSTAT: rdata = st_q.fifo[0];
            default: hit = 1'b0;
        endcase

        if (wr && hit) begin
            case (i_paddr)
                `UOPC_ADDR_LINE: st_d.line_ctl = i_pwdata[7:0];
                `UOPC_ADDR_PWR: begin
                    st_d.sleep_guard = i_pwdata[`UOPC_SLP_GRD];
                    st_d.suspend_request = i_pwdata[`UOPC_SUSP];
                    st_d.module_operation_en = i_pwdata[`UOPC_OP_EN];
                end
                `UOPC_ADDR_EVT: clr_ev = i_pwdata[7:0];
                `UOPC_ADDR_ERREN: st_d.err_en = i_pwdata[7:0];
                `UOPC_ADDR_MAIN: begin
                    st_d.host_role_en = i_pwdata[`UOPC_HOST_EN];
                    st_d.peripheral_role_en = i_pwdata[`UOPC_PERI_EN];
                end
                default: st_d.pslverr = 1'b0;
            endcase
        end

        // Set wins over clear; flags hold until written one
        st_d.flags = ((st_q.flags & ~clr_ev) | set_ev) & `UOPC_EVT_MASK;
        // Error summary is live and read-only
        st_d.flags[`UOPC_EV_ERR] = |(i_error_flags & st_q.err_en);
        if (!st_q.module_operation_en) begin
            st_d.flags[`UOPC_EV_ERR] = 1'b0;
        end

        // Token status FIFO: clearing the token flag pops it
        pop = clr_ev[`UOPC_EV_TOKEN] && st_q.flags[`UOPC_EV_TOKEN];
        push = i_token_done && st_q.module_operation_en &&
            st_q.fifo_cnt < 3'(FIFO_DEPTH);
        if (pop) begin
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                st_d.fifo[i] = st_q.fifo[i+1];
            end
            st_d.fifo[FIFO_DEPTH-1] = 8'h00;
        end
        if (push) begin
            st_d.fifo[pop ? st_q.fifo_cnt - 3'd1 : st_q.fifo_cnt] =
                i_token_info;
        end
        st_d.fifo_cnt = st_q.fifo_cnt + {2'b00, push} - {2'b00, pop};
        // Token flag set while entries wait to be read
        st_d.flags[`UOPC_EV_TOKEN] = (st_d.fifo_cnt != 3'd0);

        // Activity pending only meaningful with sleep guard
        st_d.activity_pending = st_q.sleep_guard &&
            (i_bus_active || st_q.fifo_cnt != 3'd0);
        // Resume activity lets hardware drop the suspend request
        if (resume_hit && st_q.suspend_request) begin
            st_d.suspend_request = 1'b0;
        end

        // APB answer: one wait state, bits 31..8 read as zero
        st_d.pready = acc;
        st_d.pslverr = acc && !hit;
        st_d.prdata = rd ? {24'h00_0000, rdata} : 32'h0000_0000;

        // Resistors: software bits when dual-role on, else role driven
        if (dual) begin
            st_d.pins[6:3] = st_q.line_ctl[7:4];
        end else begin
            st_d.pins[6] = st_q.peripheral_role_en && !st_q.host_role_en;
            st_d.pins[5] = 1'b0;
            st_d.pins[4] = st_q.host_role_en;
            st_d.pins[3] = st_q.host_role_en;
        end
        st_d.pins[2] = st_q.line_ctl[`UOPC_BUS_PWR];
        st_d.pins[1] = st_q.line_ctl[`UOPC_CHG_SEL];
        st_d.pins[0] = st_q.line_ctl[`UOPC_DIS_EN];
        if (!st_q.module_operation_en) begin
            st_d.pins = 7'h00;
        end
        st_d.pwr = {st_q.module_operation_en,
            st_q.suspend_request, st_q.suspend_request};
    end

    // -------------------------------------------------------------
    // State register
    // -------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign o_prdata = st_q.prdata;
    assign o_pready = st_q.pready;
    assign o_pslverr = st_q.pslverr;
    assign o_dplus_pullup_en = st_q.pins[6];
    assign o_dminus_pullup_en = st_q.pins[5];
    assign o_dplus_pulldown_en = st_q.pins[4];
    assign o_dminus_pulldown_en = st_q.pins[3];
    assign o_bus_power_on = st_q.pins[2];
    assign o_bus_charge_select = st_q.pins[1];
    assign o_bus_discharge_en = st_q.pins[0];
    assign o_module_en = st_q.pwr[2];
    assign o_usb_clk_gate = st_q.pwr[1];
    assign o_xcvr_low_power = st_q.pwr[0];
endmodule : uopc_top

//--- uopc_usb_peer.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far-side bus peer driving D+/D-
// ------------------------------------------------------------
module uopc_usb_peer (
    // Clock and line mode: 0 J, 1 K, 2 SE0, 3 traffic
    input wire logic i_clk,
    input wire logic [1:0] i_mode,
    // Data lines
    output logic o_dplus,
    output logic o_dminus
);
    logic tog_q = 1'b0;
    // Full-speed levels; traffic flips J/K so no line timer matures
    always_ff @(posedge i_clk) begin
        tog_q <= ~tog_q;
        case (i_mode)
            2'd0: {o_dplus, o_dminus} <= 2'b10;
            2'd1: {o_dplus, o_dminus} <= 2'b01;
            2'd2: {o_dplus, o_dminus} <= 2'b00;
            default: {o_dplus, o_dminus} <= {tog_q, ~tog_q};
        endcase
    end
endmodule : uopc_usb_peer

//--- uopc_top_assertions.sv
`timescale 1ns/100ps
`include "uopc_cfg.svh"
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module uopc_top_assertions #(
    parameter int IDLE_CYC = 50,
    parameter int KSTATE_CYC = 25
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Line and power outputs
    input wire logic o_dplus_pullup_en,
    input wire logic o_dminus_pullup_en,
    input wire logic o_dplus_pulldown_en,
    input wire logic o_dminus_pulldown_en,
    input wire logic o_bus_power_on,
    input wire logic o_bus_charge_select,
    input wire logic o_bus_discharge_en,
    input wire logic o_module_en,
    input wire logic o_usb_clk_gate,
    input wire logic o_xcvr_low_power
);
    logic [3:0] line_q;
    logic rd_c;
    logic [6:0] outs;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Read completion and the resistor/power outputs as one vector
    assign rd_c = o_pready && !i_pwrite;
    assign outs = {o_dplus_pullup_en, o_dminus_pullup_en,
        o_dplus_pulldown_en, o_dminus_pulldown_en, o_bus_power_on,
        o_bus_charge_select, o_bus_discharge_en};
    // Last resistor pattern written; a struct copy would not help here
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) line_q <= 4'h0;
        else if (o_pready && i_pwrite && i_paddr == `UOPC_ADDR_LINE)
            line_q <= i_pwdata[7:4];
    end
    a_pready_wait: assert property (
        i_psel && i_penable && !o_pready |=> o_pready)
        else $error("access not answered after one wait state");
    a_pready_cause: assert property (
        o_pready |-> i_psel && i_penable && $past(i_psel && i_penable))
        else $error("ready without a held access");
    a_slverr_map: assert property (o_pready && !(i_paddr inside
        {`UOPC_ADDR_LINE, `UOPC_ADDR_PWR, `UOPC_ADDR_EVT,
        `UOPC_ADDR_ERREN, `UOPC_ADDR_MAIN, `UOPC_ADDR_TSTAT})
        |-> o_pslverr) else $error("unmapped access not refused");
    a_upper_zero: assert property (
        o_pready |-> o_prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_reserved_bits: assert property (
        rd_c |-> !(i_paddr == `UOPC_ADDR_EVT && o_prdata[6])
        && !(i_paddr == `UOPC_ADDR_PWR && (o_prdata[7:0] & 8'h6C) != 0))
        else $error("unimplemented bit reads as one");
    a_act_guard: assert property (
        rd_c && i_paddr == `UOPC_ADDR_PWR && !o_prdata[4] |-> !o_prdata[7])
        else $error("activity pending without sleep guard");
    a_line_follow: assert property (
        o_pready && i_pwrite && i_paddr == `UOPC_ADDR_LINE && i_pwdata[2]
        && o_module_en |-> ##[1:3] outs[6:3] == line_q)
        else $error("resistors do not follow written bits");
    a_suspend_pair: assert property (
        o_usb_clk_gate == o_xcvr_low_power)
        else $error("clock gate and transceiver state differ");
    a_module_off: assert property (
        !o_module_en && $past(!o_module_en) |-> outs == 7'h00
        && !o_usb_clk_gate) else $error("outputs active while disabled");
endmodule : uopc_top_assertions

//--- tb_usb_otg_power_and_event_control.sv
`timescale 1ns/100ps
`include "uopc_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module tb_usb_otg_power_and_event_control;
    localparam int IDLE_N = 50;
    localparam int K_N = 25;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
    logic i_pwrite = 1'b0, i_low_speed = 1'b0, i_stall_sent = 1'b0;
    logic i_token_done = 1'b0, i_sof_seen = 1'b0, i_sof_threshold = 1'b0;
    logic i_bus_active = 1'b0, i_dplus, i_dminus, last_err;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000, o_prdata;
    logic [7:0] i_token_info = 8'h00, i_error_flags = 8'h00;
    logic o_pready, o_pslverr, o_dplus_pullup_en, o_dminus_pullup_en;
    logic o_dplus_pulldown_en, o_dminus_pulldown_en, o_bus_power_on;
    logic o_bus_charge_select, o_bus_discharge_en, o_module_en;
    logic o_usb_clk_gate, o_xcvr_low_power;
    logic [1:0] mode = 2'd3;
    logic [6:0] lines;
    int fails = 0;
    int n_compared = 0;
    // Resistor and power outputs gathered for compact checks
    assign lines = {o_dplus_pullup_en, o_dminus_pullup_en,
        o_dplus_pulldown_en, o_dminus_pulldown_en, o_bus_power_on,
        o_bus_charge_select, o_bus_discharge_en};
    // 10 MHz clock
    always #50 i_clk = ~i_clk;
    uopc_top #(.IDLE_CYC(IDLE_N), .KSTATE_CYC(K_N)) dut (.i_clk, .i_reset_n,
        .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_dplus, .i_dminus, .i_low_speed,
        .i_stall_sent, .i_token_done, .i_token_info, .i_sof_seen,
        .i_sof_threshold, .i_error_flags, .i_bus_active, .o_dplus_pullup_en,
        .o_dminus_pullup_en, .o_dplus_pulldown_en, .o_dminus_pulldown_en,
        .o_bus_power_on, .o_bus_charge_select, .o_bus_discharge_en,
        .o_module_en, .o_usb_clk_gate, .o_xcvr_low_power);
    uopc_usb_peer u_peer (.i_clk, .i_mode(mode), .o_dplus(i_dplus),
        .o_dminus(i_dminus));
    // One APB transfer; waits for ready under a bound, releases after it
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        r = o_prdata;
        last_err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        `CHK(r, e)
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    // Reset values, unmapped address, upper byte of a write
    task automatic t_regs();
        rd(`UOPC_ADDR_LINE, 32'h0000_0000);
        rd(`UOPC_ADDR_PWR, 32'h0000_0000);
        rd(`UOPC_ADDR_EVT, 32'h0000_0000);
        rd(`UOPC_ADDR_TSTAT, 32'h0000_0000);
        rd(12'h018, 32'h0000_0000);
        `CHK(last_err, 1'b1)
        wr(`UOPC_ADDR_ERREN, 32'hFFFF_FF5A);
        rd(`UOPC_ADDR_ERREN, 32'h0000_005A);
    endtask : t_regs
    // Resistor controls under software and under hardware control
    task automatic t_lines();
        wr(`UOPC_ADDR_PWR, 32'h0000_0001);
        wr(`UOPC_ADDR_MAIN, 32'h0000_0008);
        wr(`UOPC_ADDR_LINE, 32'hFFFF_FFA4);
        rd(`UOPC_ADDR_LINE, 32'h0000_00A4);
        `CHK(lines, 7'h50)
        wr(`UOPC_ADDR_LINE, 32'h0000_005F);
        tick(3);
        `CHK(lines, 7'h2F)
        wr(`UOPC_ADDR_LINE, 32'h0000_00F0);
        tick(3);
        `CHK(lines, 7'h18)
        wr(`UOPC_ADDR_MAIN, 32'h0000_0001);
        tick(3);
        `CHK(lines, 7'h40)
    endtask : t_lines
    // Guard, activity pending, suspend and resume from K-state
    task automatic t_power();
        i_bus_active <= 1'b1;
        wr(`UOPC_ADDR_PWR, 32'h0000_0013);
        tick(3);
        `CHK({o_usb_clk_gate, o_xcvr_low_power}, 2'h3)
        rd(`UOPC_ADDR_PWR, 32'h0000_0093);
        i_bus_active <= 1'b0;
        tick(2);
        rd(`UOPC_ADDR_PWR, 32'h0000_0013);
        i_bus_active <= 1'b1;
        wr(`UOPC_ADDR_PWR, 32'h0000_0003);
        rd(`UOPC_ADDR_PWR, 32'h0000_0003);
        mode <= 2'd1;
        tick(40);
        mode <= 2'd3;
        rd(`UOPC_ADDR_PWR, 32'h0000_0001);
        rd(`UOPC_ADDR_EVT, 32'h0000_0020);
        wr(`UOPC_ADDR_EVT, 32'h0000_00FF);
        rd(`UOPC_ADDR_EVT, 32'h0000_0000);
        // Low speed: K is D+ high, the full-speed J level
        i_low_speed <= 1'b1;
        mode <= 2'd0;
        tick(40);
        mode <= 2'd3;
        i_low_speed <= 1'b0;
        rd(`UOPC_ADDR_EVT, 32'h0000_0020);
        wr(`UOPC_ADDR_EVT, 32'h0000_00FF);
    endtask : t_power
    // Engine events, partial clears, error mask, token FIFO, host role
    task automatic t_events();
        i_stall_sent <= 1'b1;
        i_sof_seen <= 1'b1;
        tick(1);
        i_stall_sent <= 1'b0;
        i_sof_seen <= 1'b0;
        tick(3);
        rd(`UOPC_ADDR_EVT, 32'h0000_0084);
        wr(`UOPC_ADDR_EVT, 32'h0000_0004);
        rd(`UOPC_ADDR_EVT, 32'h0000_0080);
        wr(`UOPC_ADDR_EVT, 32'h0000_0080);
        i_error_flags <= 8'h05;
        rd(`UOPC_ADDR_EVT, 32'h0000_0000);
        i_error_flags <= 8'h12;
        rd(`UOPC_ADDR_EVT, 32'h0000_0002);
        i_error_flags <= 8'h00;
        i_token_info <= 8'h11;
        i_token_done <= 1'b1;
        tick(1);
        i_token_done <= 1'b0;
        i_token_info <= 8'h22;
        tick(1);
        i_token_done <= 1'b1;
        tick(1);
        i_token_done <= 1'b0;
        rd(`UOPC_ADDR_EVT, 32'h0000_0008);
        rd(`UOPC_ADDR_TSTAT, 32'h0000_0011);
        wr(`UOPC_ADDR_EVT, 32'h0000_0008);
        rd(`UOPC_ADDR_EVT, 32'h0000_0008);
        rd(`UOPC_ADDR_TSTAT, 32'h0000_0022);
        wr(`UOPC_ADDR_EVT, 32'h0000_0008);
        rd(`UOPC_ADDR_EVT, 32'h0000_0000);
        wr(`UOPC_ADDR_MAIN, 32'h0000_0008);
        i_stall_sent <= 1'b1;
        i_sof_threshold <= 1'b1;
        tick(1);
        i_stall_sent <= 1'b0;
        i_sof_threshold <= 1'b0;
        rd(`UOPC_ADDR_EVT, 32'h0000_0004);
        wr(`UOPC_ADDR_EVT, 32'h0000_00FF);
        wr(`UOPC_ADDR_MAIN, 32'h0000_0001);
    endtask : t_events
    // Bus reset timing, re-arm after leaving reset, idle detect
    task automatic t_bus();
        mode <= 2'd2;
        tick(20);
        mode <= 2'd3;
        rd(`UOPC_ADDR_EVT, 32'h0000_0000);
        mode <= 2'd2;
        tick(40);
        rd(`UOPC_ADDR_EVT, 32'h0000_0001);
        wr(`UOPC_ADDR_EVT, 32'h0000_0001);
        tick(40);
        rd(`UOPC_ADDR_EVT, 32'h0000_0000);
        mode <= 2'd0;
        tick(IDLE_N + 20);
        rd(`UOPC_ADDR_EVT, 32'h0000_0010);
        mode <= 2'd2;
        tick(40);
        rd(`UOPC_ADDR_EVT, 32'h0000_0011);
        mode <= 2'd3;
        wr(`UOPC_ADDR_EVT, 32'h0000_00FF);
        rd(`UOPC_ADDR_EVT, 32'h0000_0000);
    endtask : t_bus
    // Orderly shutdown: roles first, then operation enable
    task automatic t_off();
        `CHK(o_module_en, 1'b1)
        wr(`UOPC_ADDR_MAIN, 32'h0000_0000);
        wr(`UOPC_ADDR_LINE, 32'h0000_0000);
        wr(`UOPC_ADDR_PWR, 32'h0000_0000);
        i_stall_sent <= 1'b1;
        tick(1);
        i_stall_sent <= 1'b0;
        tick(3);
        `CHK({o_module_en, lines, o_usb_clk_gate}, 9'h000)
        rd(`UOPC_ADDR_EVT, 32'h0000_0000);
    endtask : t_off
    task automatic give_verdict();
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    // Main sequence after an 8-cycle reset
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_regs();
        t_lines();
        t_power();
        t_events();
        t_bus();
        t_off();
        give_verdict();
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #(100 * 20000);
        fails++;
        give_verdict();
    end
endmodule : tb_usb_otg_power_and_event_control
bind uopc_top uopc_top_assertions #(.IDLE_CYC(IDLE_CYC),
    .KSTATE_CYC(KSTATE_CYC)) u_chk (.i_clk, .i_reset_n, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .o_dplus_pullup_en, .o_dminus_pullup_en,
    .o_dplus_pulldown_en, .o_dminus_pulldown_en, .o_bus_power_on,
    .o_bus_charge_select, .o_bus_discharge_en, .o_module_en,
    .o_usb_clk_gate, .o_xcvr_low_power);
